/* pc_seq_pkg.sv */
package pc_seq_pkg;
  // Widths of the sequencer
  localparam int PC_MAX_W   = 14;
  localparam int TARGET_W   = 13;
  localparam int PAGE_W     = 8;
  localparam int BANK_BIT   = 5;
  localparam int UPPER_W    = 6;
  // Instruction cycle is four system clocks
  localparam int             SYS_PER_CYCLE = 4;
  localparam logic [1:0]     CE_LAST       = 2'(SYS_PER_CYCLE - 1);
  // Register indices; byte address is four times the index
  localparam int             REG_BYTE_SCALE  = 4;
  localparam logic [7:0]     IDX_BANK_SEL    = 8'h04;
  localparam logic [7:0]     IDX_PC_LOW      = 8'h06;
  localparam logic [7:0]     IDX_TBL_PTR_LOW = 8'h07;
  localparam logic [7:0]     IDX_TBL_HIGH    = 8'h08;
  localparam logic [7:0]     IDX_TBL_PTR_UP  = 8'h1f;
  // Reset values
  localparam logic [7:0]     RST_REG8 = 8'h00;
  localparam logic [13:0]    RST_PC   = 14'h0000;
  // Vector locations, all in bank 0
  localparam logic [13:0]    VEC_EXT  = 14'h0004;
  localparam logic [13:0]    VEC_TMR0 = 14'h0008;
  localparam logic [13:0]    VEC_COUNTER_ONE_CLOCK_PIN = 14'h000c;
  localparam logic [13:0]    VEC_RTC  = 14'h0014;
  localparam logic [13:0]    VEC_DIAL = 14'h0018;
  // Interrupt source positions, highest priority first
  localparam int INT_N    = 5;
  localparam int INT_EXT  = 0;
  localparam int INT_TMR0 = 1;
  localparam int INT_COUNTER_ONE_CLOCK_PIN = 2;
  localparam int INT_RTC  = 3;
  localparam int INT_DIAL = 4;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FLUSH = 3'b010,
    ST_TABLE = 3'b100
  } seq_state_t;
endpackage

/* program_counter_sequencer.sv */
`timescale 1ns/1ps
module program_counter_sequencer #(
  parameter int PC_W = pc_seq_pkg::PC_MAX_W
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [9:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_cycle_ce,
  input  wire logic        i_op_jump,
  input  wire logic        i_op_call,
  input  wire logic        i_op_return,
  input  wire logic        i_op_skip,
  input  wire logic        i_op_tbl_cur,
  input  wire logic        i_op_tbl_last,
  input  wire logic [12:0] i_target,
  output logic      [13:0] o_rom_addr,
  input  wire logic [15:0] i_rom_data,
  output logic             o_fetch_valid,
  output logic             o_exec_dummy,
  output logic             o_tbl_low_wr,
  output logic      [7:0]  o_tbl_low_data,
  output logic             o_stack_push,
  output logic             o_stack_pop,
  output logic      [13:0] o_push_addr,
  input  wire logic [13:0] i_pop_addr,
  input  wire logic        i_stack_full,
  input  wire logic        i_ext_int_req,
  input  wire logic        i_tmr0_ovf,
  input  wire logic        i_counter_one_clock_pin_ovf,
  input  wire logic        i_rtc_timeout,
  input  wire logic [4:0]  i_int_en,
  input  wire logic        i_hook_switch_input,
  input  wire logic        i_hold_line_input,
  input  wire logic        i_handsfree_input,
  output logic      [4:0]  o_int_ack,
  output logic      [13:0] o_pc
);

  localparam logic [13:0] PC_MASK = 14'((15'h1 << PC_W) - 15'h1);
  localparam bit          TWO_BANK = (PC_W == pc_seq_pkg::PC_MAX_W);

  function automatic logic [13:0] fit_pc(input logic [13:0] a);
    fit_pc = a & PC_MASK;
  endfunction

  function automatic logic [13:0] step_pc(input logic [13:0] a);
    logic [12:0] low;
    low = a[12:0] + 13'h1;
    step_pc = fit_pc({a[13], low});
  endfunction

  logic [1:0]                 div_cnt_reg;
  logic                       ce;
  pc_seq_pkg::seq_state_t     state_reg;
  logic [13:0]                pc_reg;
  logic [7:0]                 bank_sel_reg;
  logic [7:0]                 tbl_low_reg;
  logic [7:0]                 tbl_up_reg;
  logic [7:0]                 tbl_high_reg;
  logic                       pcl_pend_reg;
  logic [7:0]                 pcl_val_reg;
  logic                       tbl_last_reg;
  logic [2:0]                 dial_d_reg;
  logic                       dial_flag_reg;
  logic [13:0]                tbl_addr;
  logic [4:0]                 int_req;
  logic [4:0]                 int_sel;
  logic [13:0]                int_vec;
  logic                       int_take;
  logic                       plain_cycle;
  logic                       apb_acc;
  logic                       apb_wr;
  logic [7:0]                 reg_idx;
  logic                       idx_ok;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      div_cnt_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end
  assign ce         = (div_cnt_reg == pc_seq_pkg::CE_LAST);
  assign o_cycle_ce = ce;

  // APB slave, zero wait states
  assign reg_idx  = i_paddr[9:2];
  assign apb_acc  = i_psel && i_penable;
  assign apb_wr   = apb_acc && i_pwrite;
  assign o_pready = 1'b1;
  always_comb begin
    idx_ok = (i_paddr[1:0] == 2'h0) &&
             (reg_idx == pc_seq_pkg::IDX_BANK_SEL || reg_idx == pc_seq_pkg::IDX_PC_LOW ||
              reg_idx == pc_seq_pkg::IDX_TBL_PTR_LOW || reg_idx == pc_seq_pkg::IDX_TBL_HIGH ||
              reg_idx == pc_seq_pkg::IDX_TBL_PTR_UP);
  end
  assign o_pslverr = apb_acc && !idx_ok;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (reg_idx)
        pc_seq_pkg::IDX_BANK_SEL:    o_prdata <= {24'h000000, bank_sel_reg};
        pc_seq_pkg::IDX_PC_LOW:      o_prdata <= {24'h000000, pc_reg[7:0]};
        pc_seq_pkg::IDX_TBL_PTR_LOW: o_prdata <= {24'h000000, tbl_low_reg};
        pc_seq_pkg::IDX_TBL_HIGH:    o_prdata <= {24'h000000, tbl_high_reg};
        pc_seq_pkg::IDX_TBL_PTR_UP:  o_prdata <= {24'h000000, tbl_up_reg};
        default:                     o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software-written pointers; table high byte deliberately absent
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      bank_sel_reg <= pc_seq_pkg::RST_REG8;
      tbl_low_reg  <= pc_seq_pkg::RST_REG8;
      tbl_up_reg   <= pc_seq_pkg::RST_REG8;
    end else if (apb_wr && i_paddr[1:0] == 2'h0) begin
      if (reg_idx == pc_seq_pkg::IDX_BANK_SEL) begin
        bank_sel_reg <= i_pwdata[7:0];
      end
      if (reg_idx == pc_seq_pkg::IDX_TBL_PTR_LOW) begin
        tbl_low_reg <= i_pwdata[7:0];
      end
      if (reg_idx == pc_seq_pkg::IDX_TBL_PTR_UP) begin
        tbl_up_reg <= i_pwdata[7:0];
      end
    end
  end

  // low byte write held until the next cycle boundary in ST_RUN
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      pcl_pend_reg <= 1'b0;
      pcl_val_reg  <= pc_seq_pkg::RST_REG8;
    end else if (apb_wr && i_paddr[1:0] == 2'h0 && reg_idx == pc_seq_pkg::IDX_PC_LOW) begin
      // New write wins over the consume in the same clock
      pcl_pend_reg <= 1'b1;
      pcl_val_reg  <= i_pwdata[7:0];
    end else if (ce && state_reg == pc_seq_pkg::ST_RUN) begin
      pcl_pend_reg <= 1'b0;
    end
  end

  // dialer edge detect, sticky until acknowledged
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      dial_d_reg    <= {i_handsfree_input, i_hold_line_input, i_hook_switch_input};
      dial_flag_reg <= 1'b0;
    end else begin
      dial_d_reg <= {i_handsfree_input, i_hold_line_input, i_hook_switch_input};
      if ((dial_d_reg[0] != i_hook_switch_input) || (dial_d_reg[1] && !i_hold_line_input) ||
          (!dial_d_reg[2] && i_handsfree_input)) begin
        dial_flag_reg <= 1'b1;
      end else if (o_int_ack[pc_seq_pkg::INT_DIAL]) begin
        dial_flag_reg <= 1'b0;
      end
    end
  end

  assign int_req = {dial_flag_reg, i_rtc_timeout, i_counter_one_clock_pin_ovf, i_tmr0_ovf, i_ext_int_req} & i_int_en;
  always_comb begin
    int_sel = 5'h00;
    int_vec = pc_seq_pkg::VEC_EXT;
    if (int_req[pc_seq_pkg::INT_EXT]) begin
      int_sel[pc_seq_pkg::INT_EXT] = 1'b1;
      int_vec = pc_seq_pkg::VEC_EXT;
    end else if (int_req[pc_seq_pkg::INT_TMR0]) begin
      int_sel[pc_seq_pkg::INT_TMR0] = 1'b1;
      int_vec = pc_seq_pkg::VEC_TMR0;
    end else if (int_req[pc_seq_pkg::INT_COUNTER_ONE_CLOCK_PIN]) begin
      int_sel[pc_seq_pkg::INT_COUNTER_ONE_CLOCK_PIN] = 1'b1;
      int_vec = pc_seq_pkg::VEC_COUNTER_ONE_CLOCK_PIN;
    end else if (int_req[pc_seq_pkg::INT_RTC]) begin
      int_sel[pc_seq_pkg::INT_RTC] = 1'b1;
      int_vec = pc_seq_pkg::VEC_RTC;
    end else if (int_req[pc_seq_pkg::INT_DIAL]) begin
      int_sel[pc_seq_pkg::INT_DIAL] = 1'b1;
      int_vec = pc_seq_pkg::VEC_DIAL;
    end
  end

  // Interrupts only between plain instructions, so no op is lost
  assign plain_cycle = !(i_op_jump || i_op_call || i_op_return || i_op_skip ||
                         i_op_tbl_cur || i_op_tbl_last || pcl_pend_reg);
  assign int_take  = ce && state_reg == pc_seq_pkg::ST_RUN && plain_cycle &&
                     (int_req != 5'h00) && !i_stack_full;
  assign o_int_ack = int_take ? int_sel : 5'h00;

  // Stack side effects
  assign o_stack_push = int_take ||
                        (ce && state_reg == pc_seq_pkg::ST_RUN && !pcl_pend_reg && i_op_call);
  assign o_stack_pop  = ce && state_reg == pc_seq_pkg::ST_RUN && !pcl_pend_reg &&
                        !i_op_call && !i_op_jump && i_op_return;
  assign o_push_addr  = pc_reg;

  // Sequencer state and program counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_reg    <= pc_seq_pkg::ST_RUN;
      pc_reg       <= pc_seq_pkg::RST_PC;
      tbl_last_reg <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        pc_seq_pkg::ST_RUN: begin
          if (pcl_pend_reg) begin
            pc_reg    <= fit_pc({pc_reg[13:8], pcl_val_reg});
            state_reg <= pc_seq_pkg::ST_FLUSH;
          end else if (i_op_jump || i_op_call) begin
            // target latched with the bank bit now present
            pc_reg    <= fit_pc({TWO_BANK ? bank_sel_reg[pc_seq_pkg::BANK_BIT] : 1'b0, i_target});
            state_reg <= pc_seq_pkg::ST_FLUSH;
          end else if (i_op_return) begin
            pc_reg    <= fit_pc(i_pop_addr);
            state_reg <= pc_seq_pkg::ST_FLUSH;
          end else if (i_op_skip) begin
            // dummy cycle fetches two words ahead
            pc_reg    <= step_pc(pc_reg);
            state_reg <= pc_seq_pkg::ST_FLUSH;
          end else if (i_op_tbl_cur || i_op_tbl_last) begin
            // second cycle spent on the table word
            pc_reg       <= step_pc(pc_reg);
            tbl_last_reg <= i_op_tbl_last;
            state_reg    <= pc_seq_pkg::ST_TABLE;
          end else if (int_take) begin
            pc_reg    <= int_vec;
            state_reg <= pc_seq_pkg::ST_FLUSH;
          end else begin
            pc_reg <= step_pc(pc_reg);
          end
        end
        pc_seq_pkg::ST_FLUSH: begin
          pc_reg    <= step_pc(pc_reg);
          state_reg <= pc_seq_pkg::ST_RUN;
        end
        pc_seq_pkg::ST_TABLE: begin
          state_reg <= pc_seq_pkg::ST_RUN;
        end
        default: begin
          state_reg <= pc_seq_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_comb begin
    if (tbl_last_reg) begin
      tbl_addr = fit_pc({6'h3f, tbl_low_reg});
    end else if (TWO_BANK) begin
      tbl_addr = fit_pc({tbl_up_reg[pc_seq_pkg::UPPER_W-1:0], tbl_low_reg});
    end else begin
      tbl_addr = fit_pc({pc_reg[13:8], tbl_low_reg});
    end
  end

  assign o_rom_addr    = (state_reg == pc_seq_pkg::ST_TABLE) ? tbl_addr : pc_reg;
  assign o_fetch_valid = (state_reg != pc_seq_pkg::ST_TABLE);
  assign o_exec_dummy  = (state_reg == pc_seq_pkg::ST_FLUSH);
  assign o_pc          = pc_reg;

  // table word capture, only path into the high byte
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      tbl_high_reg   <= pc_seq_pkg::RST_REG8;
      o_tbl_low_data <= pc_seq_pkg::RST_REG8;
      o_tbl_low_wr   <= 1'b0;
    end else begin
      o_tbl_low_wr <= ce && state_reg == pc_seq_pkg::ST_TABLE;
      if (ce && state_reg == pc_seq_pkg::ST_TABLE) begin
        tbl_high_reg   <= i_rom_data[15:8];
        o_tbl_low_data <= i_rom_data[7:0];
      end
    end
  end

  // Assertions
  property p_step;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ce && state_reg == pc_seq_pkg::ST_RUN && plain_cycle && !int_take |=> pc_reg == step_pc($past(pc_reg));
  endproperty
  a_step: assert property (p_step) else $error("pc did not step by one");

  property p_skip;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ce && state_reg == pc_seq_pkg::ST_RUN && !pcl_pend_reg && i_op_skip && !i_op_jump && !i_op_call &&
      !i_op_return |=> o_exec_dummy [*4] ##1 !o_exec_dummy;
  endproperty
  a_skip: assert property (p_skip) else $error("skip did not give one dummy cycle");

  property p_pcl;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ce && state_reg == pc_seq_pkg::ST_RUN && pcl_pend_reg |=>
      pc_reg[7:0] == $past(pcl_val_reg) && pc_reg[13:8] == $past(pc_reg[13:8]);
  endproperty
  a_pcl: assert property (p_pcl) else $error("low byte jump wrong");

  property p_jump;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ce && state_reg == pc_seq_pkg::ST_RUN && !pcl_pend_reg && (i_op_jump || i_op_call) |=>
      pc_reg[12:0] == ($past(i_target) & PC_MASK[12:0]) &&
      pc_reg[13] == (TWO_BANK && $past(bank_sel_reg[pc_seq_pkg::BANK_BIT])) && o_exec_dummy;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or bank wrong");

  property p_vec;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      o_int_ack != 5'h00 |-> o_stack_push && o_push_addr == pc_reg ##1 pc_reg[13] == 1'b0 && o_exec_dummy;
  endproperty
  a_vec: assert property (p_vec) else $error("interrupt not vectored in bank 0");

  property p_reset;
    @(posedge i_clk_sys) !i_rst_b |=> pc_reg == pc_seq_pkg::RST_PC && state_reg == pc_seq_pkg::ST_RUN;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear pc");

  property p_table_word_high_byte;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      $changed(tbl_high_reg) |-> $past(ce && state_reg == pc_seq_pkg::ST_TABLE);
  endproperty
  a_table_word_high_byte: assert property (p_table_word_high_byte) else $error("table high byte changed outside a table read");

  property p_tbl_word;
    @(posedge i_clk_sys) disable iff (!i_rst_b) o_tbl_low_wr |-> {tbl_high_reg, o_tbl_low_data} == $past(i_rom_data);
  endproperty
  a_tbl_word: assert property (p_tbl_word) else $error("table word bytes not split as fetched");

  property p_tbl2;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ce && state_reg == pc_seq_pkg::ST_RUN && plain_cycle == 1'b0 && !pcl_pend_reg && !i_op_jump &&
      !i_op_call && !i_op_return && !i_op_skip |=>
      (state_reg == pc_seq_pkg::ST_TABLE) [*4] ##1 state_reg == pc_seq_pkg::ST_RUN && o_tbl_low_wr;
  endproperty
  a_tbl2: assert property (p_tbl2) else $error("table read not two cycles");

  property p_full;
    @(posedge i_clk_sys) disable iff (!i_rst_b) i_stack_full |-> o_int_ack == 5'h00;
  endproperty
  a_full: assert property (p_full) else $error("interrupt taken with full stack");

  property p_ce;
    @(posedge i_clk_sys) disable iff (!i_rst_b) ce |=> !ce [*3] ##1 ce;
  endproperty
  a_ce: assert property (p_ce) else $error("instruction cycle not four clocks");

  property p_width;
    @(posedge i_clk_sys) disable iff (!i_rst_b) (pc_reg & ~PC_MASK) == 14'h0000;
  endproperty
  a_width: assert property (p_width) else $error("pc bits above width set");

  c_int:  cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_int_ack[pc_seq_pkg::INT_DIAL]);
  c_tbl:  cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_tbl_low_wr);
  c_full: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) i_stack_full && int_req != 5'h00);
  c_ret:  cover property (@(posedge i_clk_sys) disable iff (!i_rst_b) o_stack_pop);

endmodule

/* program_counter_sequencer_tb_top.sv */
`timescale 1ns/1ps
module program_counter_sequencer_tb_top;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, ce;
  logic        fetch_valid, dummy, tlw, push, pop, full, ext, t0, t1, rtc;
  logic        hook, hold, hf, er, c_push, c_pop, c_dum;
  logic [5:0]  op;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] tgt;
  logic [13:0] rom_addr, push_addr, pop_addr, pc, c_push_addr;
  logic [15:0] rom_data;
  logic [7:0]  tld;
  logic [4:0]  en, ack, c_ack;
  logic [13:0] vec [1:6] = '{14'h0008, 14'h000c, 14'h0014, 14'h0018, 14'h0018, 14'h0018};
  int          err_count = 0;
  int          n_tests = 0;
  int          n;
  int          i;

  program_counter_sequencer DUT (
    .i_clk_sys          (clk),
    .i_rst_b            (rst_b),
    .i_psel             (psel),
    .i_penable          (penable),
    .i_pwrite           (pwrite),
    .i_paddr            (paddr),
    .i_pwdata           (pwdata),
    .o_prdata           (prdata),
    .o_pready           (pready),
    .o_pslverr          (pslverr),
    .o_cycle_ce         (ce),
    .i_op_jump          (op[5]),
    .i_op_call          (op[4]),
    .i_op_return        (op[3]),
    .i_op_skip          (op[2]),
    .i_op_tbl_cur       (op[1]),
    .i_op_tbl_last      (op[0]),
    .i_target           (tgt),
    .o_rom_addr         (rom_addr),
    .i_rom_data         (rom_data),
    .o_fetch_valid      (fetch_valid),
    .o_exec_dummy       (dummy),
    .o_tbl_low_wr       (tlw),
    .o_tbl_low_data     (tld),
    .o_stack_push       (push),
    .o_stack_pop        (pop),
    .o_push_addr        (push_addr),
    .i_pop_addr         (pop_addr),
    .i_stack_full       (full),
    .i_ext_int_req      (ext),
    .i_tmr0_ovf         (t0),
    .i_counter_one_clock_pin_ovf         (t1),
    .i_rtc_timeout      (rtc),
    .i_int_en           (en),
    .i_hook_switch_input(hook),
    .i_hold_line_input  (hold),
    .i_handsfree_input  (hf),
    .o_int_ack          (ack),
    .o_pc               (pc)
  );

  always #12.5 clk = ~clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wrap_up();
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Ends in the clock just before an instruction boundary
  task align();
    do @(negedge clk); while (ce !== 1'b1);
  endtask

  // Zero wait states, but still waits on pready rather than assuming it
  task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Op held until just after the next instruction boundary; pulses captured in the boundary clock
  task issue(input logic [5:0] o, input logic [12:0] t, input logic [13:0] p);
    @(posedge clk);
    op       <= o;
    tgt      <= t;
    pop_addr <= p;
    align();
    c_ack = ack;
    c_push = push;
    c_pop = pop;
    c_push_addr = push_addr;
    c_dum = dummy;
    @(posedge clk);
    op <= 6'h00;
  endtask

  initial begin
    clk = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 10'h000; pwdata = 32'h0; op = 6'h00; tgt = 13'h0000;
    pop_addr = 14'h0000; rom_data = 16'hbbee; full = 1'b0; ext = 1'b0;
    t0 = 1'b0; t1 = 1'b0; rtc = 1'b0; en = 5'h1f; hook = 1'b0; hold = 1'b1; hf = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(pc, 32'h0);
    chk(rom_addr, 32'h0);
    align();
    n = 0;
    do begin @(negedge clk); n++; end while (ce !== 1'b1);
    chk(n, 32'h4);
    apb(1'b1, 10'h010, 8'h20);
    apb(1'b0, 10'h010, 8'h00);
    chk(rd, 32'h20);
    apb(1'b0, 10'h020, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 10'h03c, 8'h00);
    chk(er, 32'h1);
    align();
    issue(6'h20, 13'h0123, 14'h0000);
    @(negedge clk);
    chk(pc, 32'h2123);
    chk(dummy, 32'h1);
    // Bank change after the jump must not move the target
    apb(1'b1, 10'h010, 8'h00);
    issue(6'h00, 13'h0000, 14'h0000);
    @(negedge clk);
    chk(pc, 32'h2125);
    chk(c_dum, 32'h0);
    align();
    issue(6'h10, 13'h0456, 14'h0000);
    chk(c_push, 32'h1);
    chk(c_push_addr, 32'h2126);
    @(negedge clk);
    chk(pc, 32'h0456);
    align();
    issue(6'h08, 13'h0000, 14'h2170);
    chk(c_pop, 32'h1);
    @(negedge clk);
    chk(pc, 32'h2170);
    chk(dummy, 32'h1);
    align();
    issue(6'h04, 13'h0000, 14'h0000);
    @(negedge clk);
    chk(pc, 32'h2172);
    chk(dummy, 32'h1);
    align();
    apb(1'b1, 10'h018, 8'h5a);
    issue(6'h00, 13'h0000, 14'h0000);
    @(negedge clk);
    chk(pc, 32'h215a);
    chk(dummy, 32'h1);
    apb(1'b1, 10'h01c, 8'h34);
    apb(1'b1, 10'h07c, 8'h2a);
    align();
    issue(6'h02, 13'h0000, 14'h0000);
    @(negedge clk);
    chk(rom_addr, 32'h2a34);
    chk(fetch_valid, 32'h0);
    align();
    @(negedge clk);
    chk(tlw, 32'h1);
    chk(tld, 32'hee);
    chk(fetch_valid, 32'h1);
    apb(1'b0, 10'h020, 8'h00);
    chk(rd, 32'hbb);
    apb(1'b1, 10'h020, 8'hff);
    apb(1'b0, 10'h020, 8'h00);
    chk(rd, 32'hbb);
    align();
    issue(6'h01, 13'h0000, 14'h0000);
    @(negedge clk);
    chk(rom_addr, 32'h3f34);
    apb(1'b1, 10'h010, 8'h20);
    align();
    issue(6'h20, 13'h0100, 14'h0000);
    ext <= 1'b1;
    en  <= 5'h00;
    align();
    issue(6'h00, 13'h0000, 14'h0000);
    chk(c_ack, 32'h0);
    en   <= 5'h1f;
    full <= 1'b1;
    issue(6'h00, 13'h0000, 14'h0000);
    chk(c_ack, 32'h0);
    full <= 1'b0;
    issue(6'h00, 13'h0000, 14'h0000);
    chk(c_ack, 32'h1);
    chk(c_push_addr, 32'h2103);
    ext <= 1'b0;
    @(negedge clk);
    chk(pc, 32'h0004);
    align();
    issue(6'h08, 13'h0000, 14'h2103);
    @(negedge clk);
    chk(pc, 32'h2103);
    // Sources start after the dummy boundary so none is lost to it
    for (i = 1; i <= 6; i++) begin
      align();
      @(posedge clk);
      case (i)
        1: t0 <= 1'b1;
        2: t1 <= 1'b1;
        3: rtc <= 1'b1;
        4: hook <= ~hook;
        5: hold <= 1'b0;
        default: hf <= 1'b1;
      endcase
      issue(6'h00, 13'h0000, 14'h0000);
      t0  <= 1'b0;
      t1  <= 1'b0;
      rtc <= 1'b0;
      chk(c_ack, 32'h1 << ((i > 4) ? 4 : i));
      @(negedge clk);
      chk(pc, vec[i]);
    end
    wrap_up();
  end

  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
